// file: tpe_port.sv
/*
 test port enable, security lock and sector protection.
 test clock, mode select and data arrive from an outside programmer and are
 synchronised; the processor writes the enable register on its own port in
 this clock domain. memory arrays live outside: this block grants reads and takes their fail flag.
*/
`timescale 1ns/10ps
`default_nettype none
module tpe_port (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rstn,
   // system reset of the device, pin level, active low
   input  wire logic       sys_reset_n,
   // enable sources
   input  wire logic       nvm_dedicate,
   input  wire logic       test_pin_select_term,
   // processor register port
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // nonvolatile lock and protect state
   input  wire logic       lock_in,
   input  wire logic [7:0] flash_protect,
   input  wire logic [3:0] ee_protect,
   // programmer read of memory contents
   input  wire logic       prog_read_req,
   output logic            prog_read_grant,
   // test port pins
   input  wire logic       tck,
   input  wire logic       tms,
   input  wire logic       tdi,
   output logic            tdo,
   output logic            tdo_oe,
   output logic            pins_enabled,
   output logic            pin_ready_status,
   output logic            pin_error_flag,
   // memory operation outcome from the arrays, and lock state out
   input  wire logic       mem_fail,
   output logic            lock_out
);
   typedef enum logic [2:0] {
      TPE_IDLE = 3'b001,
      TPE_SHIFT = 3'b010,
      TPE_BUSY = 3'b100
   } tpe_state_e;

   logic tck_s, tms_s, tdi_s, rst_s;
   tpe_sync u_s_tck (.clock(clock), .rstn(rstn), .din(tck),         .dout(tck_s));
   tpe_sync u_s_tms (.clock(clock), .rstn(rstn), .din(tms),         .dout(tms_s));
   tpe_sync u_s_tdi (.clock(clock), .rstn(rstn), .din(tdi),         .dout(tdi_s));
   tpe_sync u_s_rst (.clock(clock), .rstn(rstn), .din(~sys_reset_n), .dout(rst_s));

   tpe_state_e st_q, st_d;
   logic [7:0] en_q, en_d;
   logic       tck_q, tck_d;
   logic [7:0] sh_q, sh_d;
   logic [3:0] cnt_q, cnt_d;
   logic [4:0] op_q, op_d;
   logic [3:0] cmd_q, cmd_d;
   logic       lock_q, lock_d;
   logic       err_q, err_d;
   logic       dis_q, dis_d;
   logic       ext_q, ext_d;
   logic       tdo_q, tdo_d;
   logic       oe_q, oe_d;
   logic       pe_q, pe_d;
   logic       rdy_q, rdy_d;
   logic       grant_q, grant_d;
   logic       lk_init_q, lk_init_d;

   logic       port_on, port_hold, rise;
   logic [3:0] f_cmd;
   logic [3:0] f_sec;
   logic       prot;

   always_comb begin
      en_d = en_q;
      // [R10] processor write; also cleared by device reset below
      if (reg_wr && reg_addr == tpe_pkg::TPE_ENABLE_OFFSET) begin
         en_d = {7'h00, reg_wdata[tpe_pkg::TPE_ENABLE_BIT]};  // [R06]
      end
      // software-enabled port loses its enable on system reset
      if (rst_s) begin
         en_d = tpe_pkg::TPE_ENABLE_RESET;  // [R10]
      end
      // [R09] [R05] three sources ored
      port_on = nvm_dedicate | en_q[tpe_pkg::TPE_ENABLE_BIT] | test_pin_select_term;
      // [R07] [R08] reset halts only when the dedicate bit is clear
      port_hold = rst_s & ~nvm_dedicate;
      tck_d = tck_s;
      rise = tck_s & ~tck_q;
      f_cmd = sh_q[3:0];
      f_sec = sh_q[7:4];
      // [R04] protect lookup: top sector bit picks eeprom
      prot = f_sec[3] ? ee_protect[f_sec[1:0]] : flash_protect[f_sec[2:0]];
   end

   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      cnt_d = cnt_q;
      op_d = op_q;
      cmd_d = cmd_q;
      lock_d = lock_q;
      err_d = err_q;
      dis_d = dis_q;
      ext_d = ext_q;
      tdo_d = tdo_q;
      lk_init_d = 1'b1;
      if (!lk_init_q) begin
         lock_d = lock_in;
      end
      // [R01] programmer reads refused while locked
      grant_d = prog_read_req & ~lock_q;
      if (rst_s && dis_q) begin
         err_d = 1'b1;  // [R11] reset after disable releases error
         dis_d = 1'b0;
         ext_d = 1'b0;
      end
      if (!port_on || port_hold) begin
         st_d = TPE_IDLE;  // [R08] abort in-progress work
         cnt_d = 4'h0;
      end else begin
         unique case (st_q)
            TPE_IDLE: begin
               if (rise && tms_s) begin
                  st_d = TPE_SHIFT;
                  cnt_d = 4'h0;
               end
            end
            TPE_SHIFT: begin
               if (rise) begin
                  sh_d = {tdi_s, sh_q[7:1]};
                  cnt_d = cnt_q + 4'h1;
                  tdo_d = sh_q[0];
               end
            end
            TPE_BUSY: begin
               op_d = op_q - 5'h1;
               if (op_q == 5'h01) begin
                  st_d = TPE_IDLE;
                  // flash program or sector erase only; eeprom has no error pin
                  if (mem_fail && !f_sec[3] && (cmd_q == tpe_pkg::TPE_CMD_PROGRAM
                      || cmd_q == tpe_pkg::TPE_CMD_SECT_ERA)) begin
                     err_d = 1'b0;  // [R11]
                  end
                  if (cmd_q == tpe_pkg::TPE_CMD_CHIP_ERA) begin
                     lock_d = 1'b0;  // [R03]
                  end
               end
            end
            default: st_d = TPE_IDLE;
         endcase
         // decode once the last frame bit is in
         if (st_q == TPE_SHIFT && cnt_q == 4'(tpe_pkg::TPE_FRAME_BITS)) begin
            cnt_d = 4'h0;
            st_d = TPE_IDLE;
            unique case (f_cmd)
               tpe_pkg::TPE_CMD_CHIP_ERA: begin
                  st_d = TPE_BUSY;  // [R02] always allowed
                  cmd_d = f_cmd;
                  op_d = 5'(tpe_pkg::TPE_OP_CYCLES);
               end
               tpe_pkg::TPE_CMD_READ, tpe_pkg::TPE_CMD_PROGRAM,
               tpe_pkg::TPE_CMD_VERIFY, tpe_pkg::TPE_CMD_SECT_ERA: begin
                  // [R01] [R02] blocked while locked; [R04] protected sector
                  if (!lock_q && !(f_cmd == tpe_pkg::TPE_CMD_SECT_ERA && prot)) begin
                     st_d = TPE_BUSY;
                     cmd_d = f_cmd;
                     op_d = 5'(tpe_pkg::TPE_OP_CYCLES);
                  end
               end
               tpe_pkg::TPE_CMD_CLEAR: err_d = 1'b1;  // [R11]
               tpe_pkg::TPE_CMD_DISABLE: dis_d = 1'b1;
               tpe_pkg::TPE_CMD_ENABLE: ext_d = 1'b1;
               default: ;
            endcase
         end
      end
      oe_d = port_on & ext_q;
      pe_d = port_on;
      // [R12] low while a program, erase or write runs
      rdy_d = !(st_q == TPE_BUSY && cmd_q != tpe_pkg::TPE_CMD_READ
                && cmd_q != tpe_pkg::TPE_CMD_VERIFY);
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st_q      <= TPE_IDLE;
         en_q      <= tpe_pkg::TPE_ENABLE_RESET;
         tck_q     <= 1'b0;
         sh_q      <= 8'h00;
         cnt_q     <= 4'h0;
         op_q      <= 5'h00;
         cmd_q     <= 4'h0;
         lock_q    <= 1'b1;
         err_q     <= 1'b1;
         dis_q     <= 1'b0;
         ext_q     <= 1'b0;
         tdo_q     <= 1'b0;
         oe_q      <= 1'b0;
         pe_q      <= 1'b0;
         rdy_q     <= 1'b1;
         grant_q   <= 1'b0;
         lk_init_q <= 1'b0;
      end else begin
         st_q      <= st_d;
         en_q      <= en_d;
         tck_q     <= tck_d;
         sh_q      <= sh_d;
         cnt_q     <= cnt_d;
         op_q      <= op_d;
         cmd_q     <= cmd_d;
         lock_q    <= lock_d;
         err_q     <= err_d;
         dis_q     <= dis_d;
         ext_q     <= ext_d;
         tdo_q     <= tdo_d;
         oe_q      <= oe_d;
         pe_q      <= pe_d;
         rdy_q     <= rdy_d;
         grant_q   <= grant_d;
         lk_init_q <= lk_init_d;
      end
   end

   assign reg_rdata        = en_q;
   assign prog_read_grant  = grant_q;
   assign tdo              = tdo_q;
   assign tdo_oe           = oe_q;
   assign pins_enabled     = pe_q;
   assign pin_ready_status = rdy_q;
   assign pin_error_flag   = err_q;
   assign lock_out         = lock_q;
endmodule
`default_nettype wire

// file: tpe_pkg.sv
/*
 test port enable and security package: register offset, field positions,
 command codes, sector counts and reset values.
 assumes the bench and the design both refer to it as tpe_pkg::name.
*/
// Operation
// R01: while locked, every memory read from programmer or test port is refused.
// R02: while locked, only full chip erase is taken; other program/erase/verify blocked.
// R03: finished full chip erase clears lock; part becomes blank and unsecured.
// R04: each flash and eeprom sector has a protect bit; protected sectors not erased.
// R05: enable register bit 0 turns test port off at 0, on at 1.
// R06: software writes zero to enable register bits 1 to 7.
// R07: with nonvolatile dedicate bit set, system reset never stops test port.
// R08: with only software enable, system reset aborts and blocks test port work.
// R09: test pins enabled by dedicate bit, software enable bit or product term.
// R10: enable register at offset c7; reset or processor write clears enable bit.
// R11: error pin low on flash erase/program failure until clear, or disable then reset; code flags sector erase and program only, not chip erase.
// R12: ready pin high while readable, low during flash program/erase or eeprom write.
`default_nettype none
package tpe_pkg;
   localparam logic [7:0] TPE_ENABLE_OFFSET = 8'hc7;
   localparam int         TPE_ENABLE_BIT    = 0;
   localparam logic [7:0] TPE_ENABLE_RESET  = 8'h00;
   localparam int         TPE_FLASH_SECTORS = 8;
   localparam int         TPE_EE_SECTORS    = 4;
   localparam int         TPE_OP_CYCLES     = 16;
   // test port commands, shifted in lsb first on the data pin
   localparam logic [3:0] TPE_CMD_NOP       = 4'h0;
   localparam logic [3:0] TPE_CMD_READ      = 4'h1;
   localparam logic [3:0] TPE_CMD_PROGRAM   = 4'h2;
   localparam logic [3:0] TPE_CMD_SECT_ERA  = 4'h3;
   localparam logic [3:0] TPE_CMD_VERIFY    = 4'h4;
   localparam logic [3:0] TPE_CMD_CHIP_ERA  = 4'h5;
   localparam logic [3:0] TPE_CMD_CLEAR     = 4'h6;
   localparam logic [3:0] TPE_CMD_DISABLE   = 4'h7;
   localparam logic [3:0] TPE_CMD_ENABLE    = 4'h8;
   // command frame: 4 command bits then 4 sector bits (bit 3 selects eeprom)
   localparam int         TPE_FRAME_BITS    = 8;
endpackage
`default_nettype wire

// file: tpe_sync.sv
/*
 two flip-flop level synchroniser.
 assumes the input may change at any time relative to clock.
*/
`timescale 1ns/10ps
`default_nettype none
module tpe_sync (
   // clock and reset
   input  wire logic clock,
   input  wire logic rstn,
   // level in and out
   input  wire logic din,
   output logic      dout
);
   logic meta_q;
   logic meta_d;
   logic sync_q;
   logic sync_d;

   always_comb begin
      meta_d = din;
      sync_d = meta_q;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign dout = sync_q;
endmodule
`default_nettype wire

// file: tpe_prog.sv
/*
 programmer model: drives test clock, mode select and data frames.
 assumes the bench calls send and the device samples the pins.
*/
`timescale 1ns/10ps
`default_nettype none
module tpe_prog (
   // test port pins
   output var logic tck,
   output var logic tms,
   output var logic tdi
);
   initial begin
      tck = 1'b0;
      tms = 1'b0;
      tdi = 1'b1;
   end
   // clock stands low between frames; data lsb first
   task automatic send(input logic [7:0] f);
      tms = 1'b1;
      #80 tck = 1'b1;
      #80 tck = 1'b0;
      tms = 1'b0;
      for (int i = 0; i < 8; i++) begin
         tdi = f[i];
         #80 tck = 1'b1;
         #80 tck = 1'b0;
      end
      tdi = ~f[7]; // released line has no pull
   endtask
endmodule
`default_nettype wire

// file: tpe_port_properties.sv
/*
 checker for tpe_port, bound to its ports.
 assumes one clock domain and rstn as its reset.
*/
`timescale 1ns/10ps
`default_nettype none
module tpe_port_chk (
   input wire logic       clock,
   input wire logic       rstn,
   input wire logic       sys_reset_n,
   input wire logic       nvm_dedicate,
   input wire logic       test_pin_select_term,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       prog_read_req,
   input wire logic       prog_read_grant,
   input wire logic       pins_enabled,
   input wire logic       pin_ready_status,
   input wire logic       pin_error_flag,
   input wire logic       lock_out
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence src_on;
      (nvm_dedicate || test_pin_select_term || reg_rdata[0]) [*3];
   endsequence
   sequence src_off;
      (!nvm_dedicate && !test_pin_select_term && !reg_rdata[0]) [*3];
   endsequence
   sequence busy_run;
      !pin_ready_status [*8];
   endsequence
   spare_bits_a: assert property (reg_rdata[7:1] == 7'h00)
      else $error("spare enable bits set");
   grant_lock_a: assert property (prog_read_grant |-> !lock_out)
      else $error("read granted while locked");
   enable_write_a: assert property (reg_wr && reg_addr == tpe_pkg::TPE_ENABLE_OFFSET
      && sys_reset_n && $past(sys_reset_n, 2) |=> reg_rdata[0] == $past(reg_wdata[0]))
      else $error("enable bit not written");
   pins_on_a: assert property (src_on |-> pins_enabled)
      else $error("pins off with a source on");
   pins_off_a: assert property (src_off |-> !pins_enabled)
      else $error("pins on with no source");
   busy_span_a: assert property (disable iff (!rstn || !sys_reset_n)
      $fell(pin_ready_status) |-> busy_run ##1 busy_run ##1 pin_ready_status)
      else $error("busy span wrong");
   lock_clear_a: assert property ($fell(lock_out) && $past(rstn, 3)
      |-> !$past(pin_ready_status) || !$past(pin_ready_status, 2))
      else $error("lock cleared without erase");
   error_set_a: assert property ($fell(pin_error_flag)
      |-> !$past(pin_ready_status) || !$past(pin_ready_status, 2))
      else $error("error set outside operation");
endmodule
bind tpe_port tpe_port_chk chk_i (.clock(clock), .rstn(rstn), .sys_reset_n(sys_reset_n),
   .nvm_dedicate(nvm_dedicate), .test_pin_select_term(test_pin_select_term),
   .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .prog_read_req(prog_read_req), .prog_read_grant(prog_read_grant),
   .pins_enabled(pins_enabled), .pin_ready_status(pin_ready_status),
   .pin_error_flag(pin_error_flag), .lock_out(lock_out));
`default_nettype wire

// file: jtag_port_enable_and_security_tb.sv
/*
 bench for tpe_port: register writes, programmer frames and checks.
 assumes tpe_prog drives the test pins.
*/
`timescale 1ns/10ps
`default_nettype none
module jtag_port_enable_and_security_tb;
   logic       clock, rstn, sys_reset_n, nvm, term, reg_wr, lock_in, req, mem_fail, b;
   logic [7:0] reg_addr, reg_wdata, fprot;
   logic [3:0] eprot;
   wire logic [7:0] rdata;
   wire logic       grant, tck, tms, tdi, pins, ready, err, lock_out, tdo, oe;
   int              err_total, check_count;
   tpe_port DUT (.clock(clock), .rstn(rstn), .sys_reset_n(sys_reset_n),
      .nvm_dedicate(nvm), .test_pin_select_term(term), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata), .lock_in(lock_in),
      .flash_protect(fprot), .ee_protect(eprot), .prog_read_req(req),
      .prog_read_grant(grant), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(oe),
      .pins_enabled(pins), .pin_ready_status(ready), .pin_error_flag(err),
      .mem_fail(mem_fail), .lock_out(lock_out));
   tpe_prog prog (.tck(tck), .tms(tms), .tdi(tdi));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
      @(negedge clock) reg_wr = 1'b0;
      repeat (2) @(negedge clock);
   endtask
   // frame, then note any busy and wait for idle again
   task automatic op(input logic [7:0] f);
      b = 1'b0;
      prog.send(f);
      repeat (40) @(negedge clock) b |= !ready;
      repeat (40) if (!ready) @(negedge clock);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      #300us err_total++;
      wrap_up();
   end
   initial begin
      {rstn, sys_reset_n, nvm, term, reg_wr, req, mem_fail, lock_in} = 8'h41;
      {reg_addr, reg_wdata, fprot, eprot} = {8'h00, 8'h00, 8'hff, 4'h0};
      repeat (16) @(negedge clock);
      rstn = 1'b1;
      repeat (3) @(negedge clock);
      chk({rdata, ready, err, lock_out}, 11'h007, "reset values");
      wr(8'hc6, 8'h01);
      chk(pins, 0, "unmapped write");
      wr(8'hc7, 8'h01);
      chk({rdata, pins}, 9'h003, "enable on");
      $display("register test done");
      req = 1'b1;
      op(8'h01);
      chk(grant, 0, "locked read");
      op(8'h02);
      chk(b, 0, "locked program");
      op(8'h04);
      chk(b, 0, "locked verify");
      op(8'h05);
      chk({b, lock_out, grant}, 3'b101, "chip erase");
      $display("lock test done");
      op(8'h23);
      chk(b, 0, "protected flash");
      op(8'h93);
      chk(b, 1, "open eeprom");
      eprot = 4'h2;
      op(8'h93);
      chk(b, 0, "protected eeprom");
      $display("protect test done");
      mem_fail = 1'b1;
      op(8'h02);
      chk({b, err}, 2'b10, "failed program");
      mem_fail = 1'b0;
      op(8'h06);
      chk(err, 1, "error cleared");
      mem_fail = 1'b1;
      op(8'h02);
      mem_fail = 1'b0;
      op(8'h87);
      chk(err, 0, "error holds after disable");
      op(8'h08);
      chk({tdo, oe}, 2'b11, "port drive enabled");
      $display("error test done");
      sys_reset_n = 1'b0;
      repeat (6) @(negedge clock);
      chk(rdata, 0, "system reset clears");
      chk({err, oe}, 2'b10, "reset after disable");
      op(8'h02);
      chk(b, 0, "blocked in reset");
      nvm = 1'b1;
      op(8'h02);
      chk({b, pins}, 2'b11, "dedicated in reset");
      {sys_reset_n, nvm, term} = 3'b101;
      repeat (4) @(negedge clock);
      chk(pins, 1, "product term");
      term = 1'b0;
      repeat (4) @(negedge clock);
      chk(pins, 0, "no source");
      $display("reset test done");
      wrap_up();
   end
endmodule
`default_nettype wire
